// File: rtl/isg_stop_gen.v
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/100ps
// Notes on behaviour
// (R1) Stop: data low, clock high, then data rises
// (R2) No stop request during receive byte transfer; set_stop does not check for a transfer here
// (R3) Receive: request stop after final-byte wait
// (R4) Transmit: request stop after ninth clock
// (R5) Never request stop with start together; a control write with both bits set passes on both here
// (R6) Request stop only while bus master
// (R7) Eight-clock wait: stop in ninth clock high
// (R8) Switch wait timing before requesting stop
// (R9) No second request before first clears
// (R10) Arbitration loss clears pending stop
// (R11) Detected stop clears the stop trigger
// (R12) Exit, disable and reset clear trigger
// (R13) Generate first stop before any detected
// (R14) Transmit status: release wait, float data
// (R15) Stop trigger reads back as zero
// (R16) Exit bit 6, enable bit 7, control register
// (R17) Stop detected flag visible to software
`include "isg_consts.vh"

module isg_stop_gen (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Interrupt
    output reg         irq_o,
    // Bus pins, open drain
    input  wire        scl_i,
    output reg         scl_o,
    output reg         scl_oe_o,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    // Rest of the controller, same clock
    input  wire        master_i,
    input  wire        arb_lost_i,
    input  wire        transmit_status_i,
    input  wire        wait_after_eight_i,
    output reg         wait_release_o,
    output reg         transmit_status_clear_o,
    output reg         stop_detect_o,
    output reg         start_trigger_o,
    output reg         acknowledge_enable_o,
    output reg         wait_timing_select_o,
    output reg         operation_enable_o
);

    // Sequencer states, one-hot
    localparam [5:0] S_IDLE  = 6'h01;
    localparam [5:0] S_FLOAT = 6'h02;
    localparam [5:0] S_LOW   = 6'h04;
    localparam [5:0] S_HIGH  = 6'h08;
    localparam [5:0] S_SETUP = 6'h10;
    localparam [5:0] S_DET   = 6'h20;

    localparam integer T_LOW_INT = `ISG_T_LOW_CYC;      // Clock low time, full width
    localparam integer T_SU_INT  = `ISG_T_SU_STO_CYC;   // Stop setup time, full width
    localparam [9:0]   T_LOW     = T_LOW_INT[9:0];      // Clock low time in cycles
    localparam [9:0]   T_SU      = T_SU_INT[9:0];       // Stop setup time in cycles

    reg  [5:0] state;          // Sequencer state
    reg  [5:0] next_state;     // Next sequencer state
    reg  [9:0] cnt;            // Timing down-counter
    reg  [9:0] next_cnt;       // Next counter value
    reg        stop_pend;      // Internal stop trigger
    reg  [1:0] sticky;         // Stop detected, arbitration lost
    reg  [1:0] mask;           // Interrupt mask, same layout
    reg        next_scl_oe;    // Next clock drive
    reg        next_sda_oe;    // Next data drive
    reg        next_wrel;      // Next wait release pulse
    wire       scl_sync;       // Synchronised clock line
    wire       stop_det;       // Stop condition seen on bus
    wire       wb_req;         // New bus request
    wire       wr_ctrl;        // Control register write
    wire       rd_status;      // Status register read
    wire       clr_cond;       // Anything that cancels the stop
    wire       set_stop;       // Stop request accepted

    // Byte-lane-0 write to a given offset
    function lane_wr;
        input [3:0] adr;
        input [3:0] target;
        begin
            lane_wr = wb_req & wb_we_i & wb_sel_i[0] & (adr == target);
        end
    endfunction

    // Bus line monitor
    isg_line_mon u_mon (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .scl_sync_o (scl_sync),
        .stop_det_o (stop_det)
    );

    assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ctrl   = lane_wr(wb_adr_i, `ISG_ADR_CTRL);
    assign rd_status = wb_req & ~wb_we_i & (wb_adr_i == `ISG_ADR_STATUS);
    // Exit written 1, enable off, or arbitration lost
    assign clr_cond  = (wr_ctrl & wb_dat_i[`ISG_CTRL_EXIT])                   // R12 R16
                     | ~operation_enable_o                                   // R12 R16
                     | arb_lost_i;                                           // R10
    // Accept a stop request only as master and with none pending
    assign set_stop  = wr_ctrl & wb_dat_i[`ISG_CTRL_STOP] & master_i & ~stop_pend;  // R6 R9

    // Wishbone answer: one cycle after request, dropped next cycle
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req & ~wb_we_i) begin
                case (wb_adr_i)
                    // Stop and exit bits always read zero
                    `ISG_ADR_CTRL: begin
                        wb_dat_o[`ISG_CTRL_STOP]   <= 1'b0;                  // R15
                        wb_dat_o[`ISG_CTRL_START]  <= start_trigger_o;
                        wb_dat_o[`ISG_CTRL_ACKE]   <= acknowledge_enable_o;
                        wb_dat_o[`ISG_CTRL_WTIM]   <= wait_timing_select_o;
                        wb_dat_o[`ISG_CTRL_ENABLE] <= operation_enable_o;    // R16
                    end
                    // Sticky events plus live state
                    `ISG_ADR_STATUS: begin
                        wb_dat_o[`ISG_ST_STOP_DET]  <= sticky[0];            // R17
                        wb_dat_o[`ISG_ST_ARB_LOST]  <= sticky[1];
                        wb_dat_o[`ISG_ST_TX_STATUS] <= transmit_status_i;
                        wb_dat_o[`ISG_ST_BUSY]      <= ~state[0];
                        wb_dat_o[`ISG_ST_MASTER]    <= master_i;
                    end
                    `ISG_ADR_MASK: begin
                        wb_dat_o[1:0] <= mask;
                    end
                    // Unmapped offsets read zero
                    default: begin
                        wb_dat_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Control bits, stop trigger and mask
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            operation_enable_o   <= 1'b0;                                    // R12
            acknowledge_enable_o <= 1'b0;
            wait_timing_select_o <= 1'b0;
            start_trigger_o      <= 1'b0;
            stop_pend            <= 1'b0;                                    // R12
            mask                 <= `ISG_MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                operation_enable_o   <= wb_dat_i[`ISG_CTRL_ENABLE];
                acknowledge_enable_o <= wb_dat_i[`ISG_CTRL_ACKE];
                wait_timing_select_o <= wb_dat_i[`ISG_CTRL_WTIM];
            end
            // Start is passed on as a one-cycle request
            start_trigger_o <= wr_ctrl & wb_dat_i[`ISG_CTRL_START];
            if (lane_wr(wb_adr_i, `ISG_ADR_MASK)) begin
                mask <= wb_dat_i[1:0];
            end
            // Clear conditions win over a new request
            if (clr_cond | stop_det) begin
                stop_pend <= 1'b0;                                           // R10 R11 R12
            end else if (set_stop) begin
                stop_pend <= 1'b1;
            end
        end
    end

    // Sticky events, set wins over read-clear
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sticky        <= `ISG_STICKY_RESET;
            irq_o         <= 1'b0;
            stop_detect_o <= 1'b0;
        end else begin
            sticky[0] <= stop_det | (sticky[0] & ~rd_status);               // R17
            sticky[1] <= arb_lost_i | (sticky[1] & ~rd_status);
            stop_detect_o <= stop_det;                                       // R17
            irq_o <= |(sticky & mask);
        end
    end

    // Sequencer next-state logic
    always @* begin
        next_state  = state;
        next_cnt    = cnt;
        next_scl_oe = scl_oe_o;
        next_sda_oe = sda_oe_o;
        next_wrel   = 1'b0;
        case (state)
            // Wait for an accepted request
            S_IDLE: begin
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
                if (set_stop & ~clr_cond) begin
                    next_cnt    = T_LOW;
                    next_scl_oe = 1'b1;
                    if (transmit_status_i) begin
                        // Release wait and let the data line float
                        next_wrel  = 1'b1;                                  // R14
                        next_state = S_FLOAT;
                    end else begin
                        next_sda_oe = 1'b1;                                 // R1
                        next_state  = S_LOW;
                    end
                end
            end
            // Data floats for one low time, then is pulled low
            S_FLOAT: begin
                if (cnt == 10'h000) begin
                    next_sda_oe = 1'b1;                                     // R1
                    next_cnt    = T_LOW;
                    next_state  = S_LOW;
                end else begin
                    next_cnt = cnt - 10'h001;
                end
            end
            // Data low under a low clock
            S_LOW: begin
                if (cnt == 10'h000) begin
                    // Releasing the clock here forms the ninth clock high
                    next_scl_oe = 1'b0;                                     // R1 R7
                    next_state  = S_HIGH;
                end else begin
                    next_cnt = cnt - 10'h001;
                end
            end
            // Wait for the clock line to read high
            S_HIGH: begin
                if (scl_sync) begin
                    next_cnt   = T_SU;
                    next_state = S_SETUP;
                end
            end
            // Setup time, then data rises
            S_SETUP: begin
                if (cnt == 10'h000) begin
                    next_sda_oe = 1'b0;                                     // R1
                    next_state  = S_DET;
                end else begin
                    next_cnt = cnt - 10'h001;
                end
            end
            // Hold off until the stop is seen on the bus
            S_DET: begin
                if (stop_det) begin
                    next_state = S_IDLE;                                    // R11
                end
            end
            default: begin
                next_state  = S_IDLE;
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
            end
        endcase
        // Cancellation releases both lines at once
        if (clr_cond & ~state[0]) begin
            next_state  = S_IDLE;                                           // R10 R12
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
        end
    end

    // Sequencer registers and pin drivers
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state                   <= S_IDLE;
            cnt                     <= 10'h000;
            scl_oe_o                <= 1'b0;
            sda_oe_o                <= 1'b0;
            scl_o                   <= 1'b0;
            sda_o                   <= 1'b0;
            wait_release_o          <= 1'b0;
            transmit_status_clear_o <= 1'b0;
        end else begin
            state                   <= next_state;
            cnt                     <= next_cnt;
            scl_oe_o                <= next_scl_oe;
            sda_oe_o                <= next_sda_oe;
            scl_o                   <= 1'b0;
            sda_o                   <= 1'b0;
            // Wait release and transmit status clear pulse together
            wait_release_o          <= next_wrel;                           // R14
            transmit_status_clear_o <= next_wrel;                           // R14
        end
    end

endmodule // isg_stop_gen

// File: rtl/isg_consts.vh
`ifndef ISG_CONSTS_VH
`define ISG_CONSTS_VH

// Register word offsets (byte addresses)
`define ISG_ADR_CTRL        4'h0
`define ISG_ADR_STATUS      4'h4
`define ISG_ADR_MASK        4'h8

// Control register field positions
`define ISG_CTRL_STOP       0
`define ISG_CTRL_START      1
`define ISG_CTRL_ACKE       2
`define ISG_CTRL_WTIM       3
`define ISG_CTRL_EXIT       6
`define ISG_CTRL_ENABLE     7

// Status register field positions
`define ISG_ST_STOP_DET     0
`define ISG_ST_ARB_LOST     1
`define ISG_ST_TX_STATUS    3
`define ISG_ST_BUSY         4
`define ISG_ST_MASTER       7

// Reset values
`define ISG_CTRL_RESET      8'h00
`define ISG_STICKY_RESET    2'h0
`define ISG_MASK_RESET      2'h0

// Bus timing, times in ns, clock in MHz
`define ISG_CLK_MHZ         200
`define ISG_T_LOW_NS        4700
`define ISG_T_SU_STO_NS     4000
`define ISG_T_LOW_CYC       ((`ISG_T_LOW_NS * `ISG_CLK_MHZ + 999) / 1000)
`define ISG_T_SU_STO_CYC    ((`ISG_T_SU_STO_NS * `ISG_CLK_MHZ + 999) / 1000)

`endif

// File: rtl/isg_line_mon.v
`timescale 1ns/100ps
// Synchronises the two bus lines and flags a stop condition
module isg_line_mon (
    input  wire clk_sys_i,
    input  wire rst_n_i,
    input  wire scl_i,
    input  wire sda_i,
    output reg  scl_sync_o,
    output reg  stop_det_o
);

    reg scl_meta;     // First stage, read only by second stage
    reg sda_meta;     // First stage, read only by second stage
    reg sda_sync;     // Synchronised data line
    reg sda_prev;     // Data line one cycle earlier
    reg scl_prev;     // Clock line one cycle earlier

    // Two-flop synchronisers plus one history stage
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            scl_meta   <= 1'b1;
            sda_meta   <= 1'b1;
            scl_sync_o <= 1'b1;
            sda_sync   <= 1'b1;
            scl_prev   <= 1'b1;
            sda_prev   <= 1'b1;
            stop_det_o <= 1'b0;
        end else begin
            scl_meta   <= scl_i;
            sda_meta   <= sda_i;
            scl_sync_o <= scl_meta;
            sda_sync   <= sda_meta;
            scl_prev   <= scl_sync_o;
            sda_prev   <= sda_sync;
            // Data rising while clock stays high
            stop_det_o <= sda_sync & ~sda_prev & scl_sync_o & scl_prev;
        end
    end

endmodule // isg_line_mon

// File: tb/isg_stop_gen_props.sv
`timescale 1ns/100ps
`include "isg_consts.vh"
// Pin-level checks of the stop generator
module isg_stop_gen_props (
    input wire        clk_sys_i,
    input wire        rst_n_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        irq_o,
    input wire        scl_i,
    input wire        sda_i,
    input wire        scl_oe_o,
    input wire        sda_oe_o,
    input wire        master_i,
    input wire        arb_lost_i,
    input wire        transmit_status_i,
    input wire        wait_release_o,
    input wire        wait_timing_select_o,
    input wire        operation_enable_o
);
    reg [4:0] idle_cnt; // Quiet cycles with both lines let go
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Keeps a new request apart from a stop still in flight
    always @(posedge clk_sys_i) begin
        if (!rst_n_i || scl_oe_o || sda_oe_o) begin
            idle_cnt <= 5'h00;
        end else if (idle_cnt != 5'h1F) begin
            idle_cnt <= idle_cnt + 5'h01;
        end
    end
    // Control write taken this edge
    sequence s_wr_ctrl;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `ISG_ADR_CTRL;
    endsequence
    // Legal stop request from an idle master
    sequence s_stop_req;
        s_wr_ctrl ##0 (wb_dat_i[7:6] == 2'b10 && wb_dat_i[1:0] == 2'b01 && operation_enable_o
            && master_i && !arb_lost_i && idle_cnt == 5'h1F);
    endsequence
    property p_wb_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("ack timing wrong");
    property p_stop_begin;
        s_stop_req |=> scl_oe_o && sda_oe_o == !$past(transmit_status_i);
    endproperty
    a_stop_begin: assert property (p_stop_begin) else $error("stop not started");
    property p_tx_float;
        s_stop_req ##0 transmit_status_i |=> wait_release_o && !sda_oe_o ##1 !wait_release_o;
    endproperty
    a_tx_float: assert property (p_tx_float) else $error("wait not released");
    property p_rise_high;
        $fell(sda_oe_o) && !$fell(scl_oe_o) && !$past(arb_lost_i) && !($past(wb_we_i) && $past(wb_dat_i[6]))
            && operation_enable_o |-> scl_i;
    endproperty
    a_rise_high: assert property (p_rise_high) else $error("data released with clock low");
    property p_arb_abort;
        arb_lost_i |=> !scl_oe_o && !sda_oe_o;
    endproperty
    a_arb_abort: assert property (p_arb_abort) else $error("arbitration loss kept stop");
    property p_exit_abort;
        s_wr_ctrl ##0 wb_dat_i[6] |=> !scl_oe_o && !sda_oe_o;
    endproperty
    a_exit_abort: assert property (p_exit_abort) else $error("exit kept stop");
    property p_disabled;
        !operation_enable_o |=> !scl_oe_o && !sda_oe_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled yet driving");
    property p_reset;
        $rose(rst_n_i) |-> !scl_oe_o && !sda_oe_o && !irq_o && !wb_ack_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_reads_zero;
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `ISG_ADR_CTRL |-> !wb_dat_o[0] && !wb_dat_o[6];
    endproperty
    a_reads_zero: assert property (p_reads_zero) else $error("trigger bit read as one");
    property p_ctrl_fields;
        s_wr_ctrl |=> operation_enable_o == $past(wb_dat_i[7]) && wait_timing_select_o == $past(wb_dat_i[3]);
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields) else $error("control fields misplaced");
endmodule // isg_stop_gen_props

// File: tb/isg_bus_peer.sv
`timescale 1ns/100ps
// Far-side device on the two-wire bus: pull-ups, clock stretch, data hold
module isg_bus_peer (
    input  wire       clk_sys_i,
    input  wire       scl_oe_i,   // Controller pulls clock low
    input  wire       sda_oe_i,   // Controller pulls data low
    input  wire [7:0] stretch_i,  // Cycles the clock is held after release
    input  wire       sda_hold_i, // Peer pulls data low
    output wire       scl_o,
    output wire       sda_o
);
    reg [7:0] hold_cnt = 8'h00; // Remaining stretch
    // Stretch timer reloads while the controller still pulls the clock
    always @(posedge clk_sys_i) begin
        if (scl_oe_i) begin
            hold_cnt <= stretch_i;
        end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 8'h01;
        end
    end
    // Open-drain wires float high when nobody pulls
    assign scl_o = !(scl_oe_i || hold_cnt != 8'h00);
    assign sda_o = !(sda_oe_i || sda_hold_i);
endmodule // isg_bus_peer

// File: tb/isg_stop_gen_tb.sv
`timescale 1ns/100ps
// Self-checking bench of the stop generator
module isg_stop_gen_tb;
    logic        clk_sys_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic        scl_i, scl_o, scl_oe_o, sda_i, sda_o, sda_oe_o, master_i, arb_lost_i;
    logic        transmit_status_i, wait_after_eight_i, wait_release_o, transmit_status_clear_o;
    logic        stop_detect_o, start_trigger_o, acknowledge_enable_o, wait_timing_select_o;
    logic        operation_enable_o, sda_hold, seen_det, seen_rel, seen_start;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0]  stretch;
    int          fail_count, tests_run;

    isg_stop_gen dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .master_i(master_i), .arb_lost_i(arb_lost_i),
        .transmit_status_i(transmit_status_i), .wait_after_eight_i(wait_after_eight_i),
        .wait_release_o(wait_release_o), .transmit_status_clear_o(transmit_status_clear_o),
        .stop_detect_o(stop_detect_o), .start_trigger_o(start_trigger_o),
        .acknowledge_enable_o(acknowledge_enable_o), .wait_timing_select_o(wait_timing_select_o),
        .operation_enable_o(operation_enable_o));
    isg_bus_peer peer_u (.clk_sys_i(clk_sys_i), .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
        .stretch_i(stretch), .sda_hold_i(sda_hold), .scl_o(scl_i), .sda_o(sda_i));

    // Compare and report
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One classic Wishbone cycle, waits for ack
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, 24'h000000, dat};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk("wb_ack_cycles", 32'h2, n);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    // Expected status word
    function automatic logic [31:0] exp_st(input logic det, input logic arb, input logic m);
        return {24'h000000, m, 5'h00, arb, det};
    endfunction
    // Verdict and end of run
    task automatic results;
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Catches stop pulses; controller drops transmit status on the clear pulse
    always @(posedge clk_sys_i) begin
        if (stop_detect_o === 1'b1) seen_det <= 1'b1;
        if (wait_release_o === 1'b1) seen_rel <= 1'b1;
        if (start_trigger_o === 1'b1) seen_start <= 1'b1;
        if (transmit_status_clear_o === 1'b1) transmit_status_i <= 1'b0;
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        fail_count++;
        results();
    end
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic [7:0]  v;
        logic        tx;
        {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, master_i, arb_lost_i} = '0;
        {transmit_status_i, wait_after_eight_i, sda_hold, seen_det, seen_rel, seen_start, stretch} = '0;
        wb_sel_i = 4'hF;
        fail_count = 0;
        tests_run = 0;
        void'($urandom(27));
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // Reset values, unmapped word included
        for (int a = 0; a < 16; a += 4) begin
            wb(1'b0, a[3:0], 8'h00, rd);
            chk("reset_read", 32'h0, rd);
        end
        master_i <= 1'b1;
        // Control fields, random ack enable and wait timing
        for (int i = 0; i < 3; i++) begin
            v = 8'h80 | (8'($urandom) & 8'h0C);
            wb(1'b1, 4'h0, v, rd);
            wb(1'b0, 4'h0, 8'h00, rd);
            chk("ctrl", {24'h0, v}, rd);
            chk("ctrl_out", {v[7], v[3], v[2]}, {operation_enable_o, wait_timing_select_o, acknowledge_enable_o});
        end
        // Start request passed on as a one-cycle pulse, written without the stop bit
        seen_start <= 1'b0;
        wb(1'b1, 4'h0, 8'h82, rd);
        @(posedge clk_sys_i);
        chk("start", 32'h1, seen_start);
        // Full stops, clock stretched, transmit status and mask varied
        for (int i = 0; i < 4; i++) begin
            tx = (i == 0) ? 1'b1 : 1'($urandom);
            stretch <= 8'($urandom_range(40, 0));
            wait_after_eight_i <= 1'($urandom);
            transmit_status_i <= tx;
            {seen_det, seen_rel} <= 2'b00;
            wb(1'b1, 4'h8, {7'h00, i[0]}, rd);
            v = 8'h81 | (8'($urandom) & 8'h0C);
            if (v[3]) wb(1'b1, 4'h0, v & 8'hFE, rd);
            wb(1'b1, 4'h0, v, rd);
            while (!seen_det && tests_run < 100000) @(posedge clk_sys_i);
            chk("stop_seen", 32'h1, seen_det);
            chk("release", tx, seen_rel);
            chk("lines", 32'h3, {scl_i, sda_i});
            repeat (3) @(posedge clk_sys_i);
            chk("irq", i[0], irq_o);
            wb(1'b0, 4'h4, 8'h00, rd);
            chk("status", exp_st(1'b1, 1'b0, 1'b1), rd);
            wb(1'b0, 4'h4, 8'h00, rd);
            chk("status_clr", exp_st(1'b0, 1'b0, 1'b1), rd);
            wb(1'b0, 4'h0, 8'h00, rd);
            chk("ctrl_after", {24'h0, v & 8'h8C}, rd);
            chk("irq_clr", 32'h0, irq_o);
        end
        // Aborts in mid-stop: arbitration loss, exit, disable
        stretch <= 8'h00;
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, 4'h0, 8'h81, rd);
            repeat (50) @(posedge clk_sys_i);
            chk("pulling", 32'h1, scl_oe_o);
            chk("drive_level", 32'h0, {scl_o, sda_o});
            if (k == 0) begin
                arb_lost_i <= 1'b1;
                @(posedge clk_sys_i);
                arb_lost_i <= 1'b0;
            end else begin
                wb(1'b1, 4'h0, (k == 1) ? 8'hC0 : 8'h00, rd);
            end
            repeat (2) @(posedge clk_sys_i);
            chk("abort", 32'h0, {scl_oe_o, sda_oe_o});
            wb(1'b0, 4'h4, 8'h00, rd);
            chk("arb_flag", exp_st(1'b0, k == 0, 1'b1), rd & 32'hFE);
            wb(1'b0, 4'h0, 8'h00, rd);
            chk("ctrl_abort", (k == 2) ? 32'h0 : 32'h80, rd);
        end
        // Stop refused outside master mode, with the controller enabled
        wb(1'b1, 4'h0, 8'h80, rd);
        master_i <= 1'b0;
        wb(1'b1, 4'h0, 8'h81, rd);
        repeat (5) @(posedge clk_sys_i);
        chk("no_master", 32'h0, {scl_oe_o, sda_oe_o});
        results();
    end
endmodule // isg_stop_gen_tb

bind isg_stop_gen isg_stop_gen_props props_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .scl_i(scl_i), .sda_i(sda_i),
    .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .master_i(master_i), .arb_lost_i(arb_lost_i),
    .transmit_status_i(transmit_status_i), .wait_release_o(wait_release_o),
    .wait_timing_select_o(wait_timing_select_o), .operation_enable_o(operation_enable_o));
